// [dv/pin_source_model.sv]
`timescale 1ns/10ps
// ------------------------------------------------
// pin and trigger source seen by the capture block
// ------------------------------------------------
// levels move only just after a clock edge, as synchronised pins would;
// slow_in adds one more cycle so the bench can try a lagging source
module pin_source_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic slow_in,
  input wire logic [4:0] level_req_in,
  output logic [3:0] pin_level_out,
  output logic trigger_level_out
);
  logic [4:0] stage_ff;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage_ff <= 5'h00;
      pin_level_out <= 4'h0;
      trigger_level_out <= 1'b0;
    end else begin
      stage_ff <= level_req_in;
      pin_level_out <= slow_in ? stage_ff[3:0] : level_req_in[3:0];
      trigger_level_out <= slow_in ? stage_ff[4] : level_req_in[4];
    end
  end
endmodule : pin_source_model

// [dv/timer_capture_input_conditioning_tb.sv]
`timescale 1ns/10ps
`include "capture_defs.svh"
module timer_capture_input_conditioning_tb;
  typedef struct {
    int ch, sel, pin, code, div, width, count, exp, ts;
  } row_t;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic clk_in, sys_rst_in, psel, penable, pwrite, err, pready, pslverr;
  logic trig_level, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] level_req;
  logic [3:0] pin_level, capture, level, is_in;
  logic [2:0] trig_sel;
  capture_pkg::oc_view_t [3:0] oc_view;
  int n_fail, tests_run, cycles;
  int cap_cnt [4];
  // ch sel pin code div width count exp ts; pin 4 is the trigger
  row_t rows [21] = '{
    '{0, 1, 0, 0, 0, 4, 3, 3, 0}, '{1, 1, 1, 1, 1, 4, 4, 2, 0},
    '{2, 1, 2, 2, 2, 8, 8, 2, 0}, '{3, 1, 3, 3, 3, 12, 8, 1, 0},
    '{0, 1, 0, 3, 0, 5, 3, 0, 0}, '{1, 1, 1, 4, 0, 20, 2, 2, 0},
    '{1, 1, 1, 4, 0, 8, 2, 0, 0}, '{2, 1, 2, 7, 0, 40, 2, 2, 0},
    '{2, 1, 2, 7, 0, 24, 2, 0, 0}, '{3, 1, 3, 12, 0, 150, 1, 1, 0},
    '{3, 1, 3, 12, 0, 100, 1, 0, 0}, '{0, 1, 0, 13, 0, 190, 1, 1, 0},
    '{0, 1, 0, 13, 0, 120, 1, 0, 0}, '{1, 1, 1, 15, 0, 280, 1, 1, 0},
    '{1, 1, 1, 15, 0, 220, 1, 0, 0}, '{0, 2, 1, 0, 0, 4, 2, 2, 0},
    '{2, 2, 3, 0, 0, 4, 2, 2, 0}, '{0, 1, 1, 0, 0, 4, 2, 0, 0},
    '{1, 3, 4, 0, 0, 4, 2, 2, 3}, '{1, 3, 4, 0, 0, 4, 2, 0, 5},
    '{3, 0, 3, 0, 0, 4, 2, 0, 0}
  };

  capture_cond #(.DTS_DIV(1), .CHANNELS(4)) i_capture_cond (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .pin_input_in(pin_level),
    .internal_trigger_feed_in(trig_level),
    .trigger_select_field_in(trig_sel), .capture_out(capture),
    .filtered_level_out(level), .chan_is_input_out(is_in),
    .oc_view_out(oc_view)
  );

  pin_source_model i_pin_source_model (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .slow_in(slow),
    .level_req_in(level_req), .pin_level_out(pin_level),
    .trigger_level_out(trig_level)
  );
  // ------------------------------------------------
  // clock, timeout, capture counting
  // ------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // sampled mid-cycle so the registered pulse has settled
  always @(negedge clk_in) begin
    for (int k = 0; k < 4; k++) begin
      if (capture[k] === 1'b1) cap_cnt[k]++;
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // select bits only land while the channel is off, so disable first
  task automatic setup_chan(input row_t r);
    logic [7:0] a;
    logic [15:0] m;
    a = (r.ch < 2) ? `OFS_MODE_A : `OFS_MODE_B;
    m = 16'((r.code << 4) | (r.div << 2) | r.sel) << ((r.ch % 2) * 8);
    trig_sel <= 3'(r.ts);
    apb(1'b1, `OFS_ENABLE, 32'h00000000);
    apb(1'b1, a, {16'h0000, m});
    apb(1'b1, `OFS_ENABLE, 32'h00000001 << (4 * r.ch));
  endtask : setup_chan

  task automatic pulses(input int pin, input int width, input int count);
    repeat (count) begin
      @(posedge clk_in);
      level_req[pin] <= 1'b1;
      repeat (width) @(posedge clk_in);
      level_req[pin] <= 1'b0;
      repeat (width - 1) @(posedge clk_in);
    end
    repeat (2 * width + 8) @(posedge clk_in);
  endtask : pulses

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    level_req = 5'h00;
    trig_sel = 3'h0;
    sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, `OFS_MODE_A, 32'h00000000);
    check(rd, 32'h00000000);
    apb(1'b0, `OFS_MODE_B, 32'h00000000);
    check(rd, 32'h00000000);
    check({capture, is_in}, 8'h00);
    apb(1'b0, 8'h28, 32'h00000000);
    check(rd, 32'h00000000);
    check({31'h00000000, err}, 32'h00000001);
    $display("reset and unmapped test done");
    apb(1'b1, `OFS_MODE_A, 32'h00005A4F);
    apb(1'b1, `OFS_MODE_B, 32'h0000C3B0);
    apb(1'b0, `OFS_MODE_A, 32'h00000000);
    check(rd, 32'h00005A4F);
    apb(1'b0, `OFS_MODE_B, 32'h00000000);
    check(rd, 32'h0000C3B0);
    check(oc_view, 32'hC3B05A4F);
    check(is_in, 4'hB);
    apb(1'b0, `OFS_STATUS, 32'h00000000);
    check(rd, 32'h000000B0);
    check({31'h00000000, err}, 32'h00000000);
    check(level, 4'h0);
    $display("layout test done");
    slow <= 1'b1;
    foreach (rows[i]) begin
      setup_chan(rows[i]);
      cap_cnt[rows[i].ch] = 0;
      pulses(rows[i].pin, rows[i].width, rows[i].count);
      check(cap_cnt[rows[i].ch], rows[i].exp);
      $display("row %0d done", i);
    end
    slow <= 1'b0;
    setup_chan('{0, 1, 0, 0, 0, 0, 0, 0, 0});
    apb(1'b0, `OFS_ENABLE, 32'h00000000);
    check(rd, 32'h00000001);
    apb(1'b1, `OFS_MODE_A, 32'h00000052);
    apb(1'b0, `OFS_MODE_A, 32'h00000000);
    check(rd, 32'h00000051);
    apb(1'b1, `OFS_ENABLE, 32'h00000000);
    apb(1'b1, `OFS_MODE_A, 32'h00000052);
    apb(1'b0, `OFS_MODE_A, 32'h00000000);
    check(rd, 32'h00000052);
    $display("select lock test done");
    setup_chan('{0, 1, 0, 0, 1, 0, 0, 0, 0});
    cap_cnt[0] = 0;
    pulses(0, 4, 1);
    apb(1'b1, `OFS_ENABLE, 32'h00000000);
    apb(1'b1, `OFS_ENABLE, 32'h00000001);
    pulses(0, 4, 1);
    check(cap_cnt[0], 0);
    pulses(0, 4, 1);
    check(cap_cnt[0], 1);
    $display("divider reset test done");
    report_and_stop();
  end
endmodule : timer_capture_input_conditioning_tb

// [logic/capture_cond.sv]
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "capture_defs.svh"
// How it works
// - codes 0100-0111 sample at base/2 or base/4, N six or eight
// - codes 1100-1111 sample at base/16 N8, or base/32 N5, 6, 8
// - channel enable low holds that channel's event divider in reset
// - divider 00 captures on every detected edge
// - divider 01, 10, 11 captures once per 2, 4, 8 events
// - select 00 makes the channel an output compare channel
// - select 01 takes the channel's own pin, 10 the paired pin
// - select 11 takes the internal trigger, only if trigger is internal
// - select field written only while the channel enable is low
// - direction of each channel comes only from its select field
// - other mode bits mean compare controls or filter/divider controls
// - mode b output view: channel four fields in bits 15 to 8
// - mode b output view: channel three fields in bits 7 to 0
// - mode b input view: channel four filter, divider, select
// - mode b input view: channel three filter, divider, select
// - mode a input view: channel one filter, divider, select
// - mode a input view: channel two filter, divider, select
// - filter changes level only after N consecutive new-level samples
// - code 0000 unfiltered at base rate; 0001-0011 kernel N 2,4,8
module capture_cond #(
  parameter int DTS_DIV = 1,
  parameter int CHANNELS = 4
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [3:0] pin_input_in,
  input wire logic internal_trigger_feed_in,
  input wire logic [2:0] trigger_select_field_in,
  output logic [3:0] capture_out,
  output logic [3:0] filtered_level_out,
  output logic [3:0] chan_is_input_out,
  output capture_pkg::oc_view_t [3:0] oc_view_out
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (DTS_DIV < 1 || DTS_DIV > 255) begin : g_bad_div
    $error("DTS_DIV must be 1 to 255");
  end
  if (CHANNELS != 4) begin : g_bad_ch
    $error("register layout serves exactly four channels");
  end

  // ---------------------------------------------------------------
  // filter code table
  // ---------------------------------------------------------------
  function automatic capture_pkg::filt_cfg_t decode_filter(
    input logic [3:0] code
  );
    capture_pkg::filt_cfg_t c;
    c = '{use_kernel: 1'b0, rate_mask: 5'h00, count: 4'h1};
    case (code)
      4'h0: c = '{1'b0, 5'h00, 4'h1};
      4'h1: c = '{1'b1, 5'h00, 4'h2};
      4'h2: c = '{1'b1, 5'h00, 4'h4};
      4'h3: c = '{1'b1, 5'h00, 4'h8};
      4'h4: c = '{1'b0, 5'h01, 4'h6};
      4'h5: c = '{1'b0, 5'h01, 4'h8};
      4'h6: c = '{1'b0, 5'h03, 4'h6};
      4'h7: c = '{1'b0, 5'h03, 4'h8};
      4'h8: c = '{1'b0, 5'h07, 4'h6};
      4'h9: c = '{1'b0, 5'h07, 4'h8};
      4'hA: c = '{1'b0, 5'h0F, 4'h5};
      4'hB: c = '{1'b0, 5'h0F, 4'h6};
      4'hC: c = '{1'b0, 5'h0F, 4'h8};
      4'hD: c = '{1'b0, 5'h1F, 4'h5};
      4'hE: c = '{1'b0, 5'h1F, 4'h6};
      4'hF: c = '{1'b0, 5'h1F, 4'h8};
      default: c = '{1'b0, 5'h00, 4'h1};
    endcase
    return c;
  endfunction : decode_filter

  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  logic [15:0] mode_a_ff;
  logic [15:0] mode_b_ff;
  logic [3:0] enable_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic setup;
  logic wr_access;
  logic mapped;
  logic [15:0] nxt_mode_a;
  logic [15:0] nxt_mode_b;
  logic [3:0] level_ff;
  logic [3:0] capture_ff;
  logic [7:0] mode_byte [4];
  capture_pkg::ic_view_t ic_view [4];

  assign setup = psel_in && !penable_in;
  assign wr_access = psel_in && penable_in && pwrite_in;
  assign mapped = paddr_in == `OFS_MODE_A || paddr_in == `OFS_MODE_B ||
                  paddr_in == `OFS_ENABLE || paddr_in == `OFS_STATUS;
  assign pready_out = 1'b1;
  assign prdata_out = prdata_ff;
  assign pslverr_out = pslverr_ff;

  // select bits keep their value while the channel is enabled, so a
  // running capture never sees its source swapped underneath it
  always_comb begin
    nxt_mode_a = pwdata_in[15:0];
    nxt_mode_b = pwdata_in[15:0];
    if (enable_ff[0]) begin
      nxt_mode_a[1:0] = mode_a_ff[1:0];
    end
    if (enable_ff[1]) begin
      nxt_mode_a[9:8] = mode_a_ff[9:8];
    end
    if (enable_ff[2]) begin
      nxt_mode_b[1:0] = mode_b_ff[1:0];
    end
    if (enable_ff[3]) begin
      nxt_mode_b[9:8] = mode_b_ff[9:8];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_a_ff <= `MODE_RESET;
      mode_b_ff <= `MODE_RESET;
      enable_ff <= `ENABLE_RESET;
    end else if (wr_access) begin
      if (paddr_in == `OFS_MODE_A) begin
        mode_a_ff <= nxt_mode_a;
      end
      if (paddr_in == `OFS_MODE_B) begin
        mode_b_ff <= nxt_mode_b;
      end
      if (paddr_in == `OFS_ENABLE) begin
        for (int i = 0; i < 4; i++) begin
          enable_ff[i] <= pwdata_in[i * `ENABLE_STRIDE];
        end
      end
    end
  end

  // read data is latched in the setup cycle; the access cycle answers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pslverr_ff <= !mapped;
      prdata_ff <= 32'h0000_0000;
      case (paddr_in)
        `OFS_MODE_A: prdata_ff[15:0] <= mode_a_ff;
        `OFS_MODE_B: prdata_ff[15:0] <= mode_b_ff;
        `OFS_ENABLE: begin
          for (int i = 0; i < 4; i++) begin
            prdata_ff[i * `ENABLE_STRIDE] <= enable_ff[i];
          end
        end
        `OFS_STATUS: begin
          prdata_ff[`STATUS_LEVEL_BASE +: 4] <= level_ff;
          prdata_ff[`STATUS_INPUT_BASE +: 4] <= chan_is_input_out;
        end
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // base sampling clock and its divided rates
  // ---------------------------------------------------------------
  logic [7:0] dts_cnt_ff;
  logic dts_tick;
  logic [4:0] rate_cnt_ff;

  assign dts_tick = dts_cnt_ff == 8'(DTS_DIV - 1);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dts_cnt_ff <= 8'h00;
    end else begin
      dts_cnt_ff <= dts_tick ? 8'h00 : dts_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rate_cnt_ff <= 5'h00;
    end else if (dts_tick) begin
      rate_cnt_ff <= rate_cnt_ff + 5'h01;
    end
  end

  logic trig_internal;
  assign trig_internal = trigger_select_field_in < `TRIG_INTERNAL_LIMIT;

  // ---------------------------------------------------------------
  // per channel conditioning
  // ---------------------------------------------------------------
  logic [3:0] raw_sel;
  logic [3:0] samp_en;
  logic [3:0] edge_hit;
  logic [2:0] psc_cnt_ff [4];
  logic [3:0] filt_cnt_ff [4];
  logic [3:0] fcode [4];
  logic [1:0] fdiv [4];
  logic [1:0] fsel [4];

  // channel one and two share mode a, three and four mode b
  assign mode_byte[0] = mode_a_ff[`CH_LO_BASE +: 8];
  assign mode_byte[1] = mode_a_ff[`CH_HI_BASE +: 8];
  assign mode_byte[2] = mode_b_ff[`CH_LO_BASE +: 8];
  assign mode_byte[3] = mode_b_ff[`CH_HI_BASE +: 8];

  for (genvar ch = 0; ch < 4; ch++) begin : g_ch
    capture_pkg::filt_cfg_t cfg;
    logic [2:0] psc_mask;

    assign ic_view[ch] = capture_pkg::ic_view_t'(mode_byte[ch]);
    assign oc_view_out[ch] = capture_pkg::oc_view_t'(mode_byte[ch]);
    assign fcode[ch] = ic_view[ch].filter_code;
    assign fdiv[ch] = ic_view[ch].capture_divider;
    assign fsel[ch] = ic_view[ch].source_select;
    assign chan_is_input_out[ch] = fsel[ch] != `SEL_OUTPUT;
    assign cfg = decode_filter(fcode[ch]);

    always_comb begin
      case (fsel[ch])
        `SEL_OWN_PIN: raw_sel[ch] = pin_input_in[ch];
        `SEL_PAIR_PIN: raw_sel[ch] = pin_input_in[ch ^ 1];
        `SEL_TRIGGER: raw_sel[ch] = internal_trigger_feed_in &&
                                    trig_internal;
        default: raw_sel[ch] = 1'b0;
      endcase
    end

    assign samp_en[ch] = cfg.use_kernel ||
        (dts_tick && (rate_cnt_ff & cfg.rate_mask) == 5'h00);

    // event counter filter; a reprogrammed shorter N still lets a
    // pending count through at once rather than wrapping
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        filt_cnt_ff[ch] <= 4'h0;
        level_ff[ch] <= 1'b0;
      end else if (samp_en[ch]) begin
        if (raw_sel[ch] == level_ff[ch]) begin
          filt_cnt_ff[ch] <= 4'h0;
        end else if (filt_cnt_ff[ch] >= cfg.count - 4'h1) begin
          level_ff[ch] <= raw_sel[ch];
          filt_cnt_ff[ch] <= 4'h0;
        end else begin
          filt_cnt_ff[ch] <= filt_cnt_ff[ch] + 4'h1;
        end
      end
    end

    // rising edge of the filtered level; polarity lives elsewhere
    assign edge_hit[ch] = samp_en[ch] && !level_ff[ch] && raw_sel[ch] &&
        filt_cnt_ff[ch] >= cfg.count - 4'h1;

    always_comb begin
      case (fdiv[ch])
        2'h0: psc_mask = 3'h0;
        2'h1: psc_mask = 3'h1;
        2'h2: psc_mask = 3'h3;
        2'h3: psc_mask = 3'h7;
        default: psc_mask = 3'h0;
      endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        psc_cnt_ff[ch] <= 3'h0;
        capture_ff[ch] <= 1'b0;
      end else if (!enable_ff[ch]) begin
        psc_cnt_ff[ch] <= 3'h0;
        capture_ff[ch] <= 1'b0;
      end else begin
        capture_ff[ch] <= 1'b0;
        if (edge_hit[ch] && chan_is_input_out[ch]) begin
          if ((psc_cnt_ff[ch] & psc_mask) == psc_mask) begin
            psc_cnt_ff[ch] <= 3'h0;
            capture_ff[ch] <= 1'b1;
          end else begin
            psc_cnt_ff[ch] <= psc_cnt_ff[ch] + 3'h1;
          end
        end
      end
    end
  end

  assign capture_out = capture_ff;
  assign filtered_level_out = level_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_psc_held;
    !enable_ff[2] |=> psc_cnt_ff[2] == 3'h0 && !capture_ff[2];
  endproperty
  a_psc_held: assert property (p_psc_held)
    else $error("divider not held while channel off");

  property p_every_edge;
    enable_ff[0] && fdiv[0] == 2'h0 && fsel[0] != `SEL_OUTPUT &&
      edge_hit[0] |=> capture_ff[0];
  endproperty
  a_every_edge: assert property (p_every_edge)
    else $error("edge without capture at divider 00");

  property p_div_two;
    enable_ff[1] && fdiv[1] == 2'h1 && fsel[1] != `SEL_OUTPUT &&
      edge_hit[1] && psc_cnt_ff[1] == 3'h0
      |=> !capture_ff[1] && psc_cnt_ff[1] == 3'h1;
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("first event of two captured");

  property p_output_quiet;
    fsel[3] == `SEL_OUTPUT |=> !capture_ff[3];
  endproperty
  a_output_quiet: assert property (p_output_quiet)
    else $error("capture on output channel");

  property p_pin_route;
    (fsel[0] == `SEL_OWN_PIN |-> raw_sel[0] == pin_input_in[0]) and
    (fsel[0] == `SEL_PAIR_PIN |-> raw_sel[0] == pin_input_in[1]);
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("channel one source misrouted");

  property p_trig_gate;
    fsel[1] == `SEL_TRIGGER && !trig_internal |-> raw_sel[1] == 1'b0;
  endproperty
  a_trig_gate: assert property (p_trig_gate)
    else $error("trigger used while not internal");

  property p_sel_locked;
    enable_ff[0] && wr_access && paddr_in == `OFS_MODE_A
      |=> fsel[0] == $past(fsel[0]);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("select changed while enabled");

  property p_level_needs_sample;
    $changed(level_ff[2]) |-> $past(samp_en[2]);
  endproperty
  a_level_needs_sample: assert property (p_level_needs_sample)
    else $error("filter moved without a sample");

  property p_kernel_n2;
    (fcode[1] == 4'h1 && raw_sel[1] != level_ff[1] &&
      $stable(raw_sel[1]))[*2] |=> level_ff[1] == $past(raw_sel[1]);
  endproperty
  a_kernel_n2: assert property (p_kernel_n2)
    else $error("two-sample filter too slow");

  // a reprogrammed code may sample at once, so only a kept code counts
  property p_rate_half;
    fcode[1] == 4'h4 && samp_en[1] |=> !samp_en[1] || fcode[1] != 4'h4;
  endproperty
  a_rate_half: assert property (p_rate_half)
    else $error("base/2 sampled twice in a row");

  property p_rate_32;
    fcode[0] == 4'hD && samp_en[0]
      |=> (!samp_en[0] || fcode[0] != 4'hD) [*8];
  endproperty
  a_rate_32: assert property (p_rate_32)
    else $error("base/32 sampled too often");

  property p_direction;
    chan_is_input_out[3] == (mode_b_ff[9:8] != `SEL_OUTPUT);
  endproperty
  a_direction: assert property (p_direction)
    else $error("channel four direction wrong");

  c_capture_div8: cover property (fdiv[3] == 2'h3 && capture_ff[3]);
  c_trigger_capture: cover property (fsel[1] == `SEL_TRIGGER &&
                                     capture_ff[1]);
  c_slow_filter: cover property (fcode[1] == 4'hF && $rose(level_ff[1]));
  c_locked_write: cover property (enable_ff[0] && wr_access &&
                                  paddr_in == `OFS_MODE_A);

endmodule : capture_cond

// [logic/capture_defs.svh]
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define OFS_MODE_A 8'h18
`define OFS_MODE_B 8'h1C
`define OFS_ENABLE 8'h20
`define OFS_STATUS 8'h24
`define MODE_RESET 16'h0000
`define ENABLE_RESET 4'h0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CH_LO_BASE 0
`define CH_HI_BASE 8
`define ENABLE_STRIDE 4
`define STATUS_LEVEL_BASE 0
`define STATUS_INPUT_BASE 4

// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define SEL_OUTPUT 2'h0
`define SEL_OWN_PIN 2'h1
`define SEL_PAIR_PIN 2'h2
`define SEL_TRIGGER 2'h3
`define TRIG_INTERNAL_LIMIT 3'h4

`endif

// [logic/capture_pkg.sv]
package capture_pkg;

  // ---------------------------------------------------------------
  // channel mode byte, output view and input view
  // ---------------------------------------------------------------
  typedef struct packed {
    logic clear_enable;
    logic [2:0] output_mode;
    logic preload_enable;
    logic fast_enable;
    logic [1:0] source_select;
  } oc_view_t;

  typedef struct packed {
    logic [3:0] filter_code;
    logic [1:0] capture_divider;
    logic [1:0] source_select;
  } ic_view_t;

  // sample rate mask and event count decoded from a filter code
  typedef struct packed {
    logic use_kernel;
    logic [4:0] rate_mask;
    logic [3:0] count;
  } filt_cfg_t;

endpackage : capture_pkg
